// *** rtl/cbc_bus_ctl.sv ***
/*
 Bus control and address generation of the processor core: reset start-up,
 maskable interrupt entry, effective addresses of every addressing mode,
 bus direction control and the on-chip eight-bit port.
 Assumes the decoder issues one command per step on the cmd ports, asks for
 an opcode fetch only at an instruction boundary, and that memory answers a
 read within the same clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl
	import cbc_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	input  wire logic       cpu_reset_n_i,
	input  wire logic       irq_req_n_i,
	input  wire logic       address_drive_enable_i,
	output logic     [15:0] address_lines_o,
	output logic            address_lines_oe_o,
	input  wire logic [7:0] data_lines_i,
	output logic      [7:0] data_lines_o,
	output logic            data_lines_oe_o,
	output logic            rw_o,
	input  wire logic [7:0] port_pins_i,
	output logic      [7:0] port_pins_o,
	output logic      [7:0] port_pins_oe_o,
	input  wire logic       cmd_valid_i,
	output logic            cmd_ready_o,
	input  wire cbc_mode_t  cmd_mode_i,
	input  wire logic       cmd_write_i,
	input  wire logic [7:0] cmd_wdata_i,
	input  wire logic [7:0] cmd_op1_i,
	input  wire logic [7:0] cmd_op2_i,
	input  wire logic [7:0] cmd_x_i,
	input  wire logic [7:0] cmd_y_i,
	input  wire logic       cmd_taken_i,
	input  wire logic [7:0] status_i,
	input  wire logic [7:0] stack_ptr_i,
	input  wire logic       mask_set_i,
	input  wire logic       mask_clear_i,
	output logic            done_o,
	output logic      [7:0] rdata_o,
	output logic     [15:0] ea_o,
	output logic     [15:0] pc_o,
	output logic            irq_mask_o,
	output logic            irq_taken_o,
	output logic            stack_adjust_o
);

	cbc_state_t  state_r;
	cbc_state_t  state_nxt;
	logic [15:0] addr_r;
	logic [15:0] addr_nxt;
	logic        wr_r;
	logic        wr_nxt;
	logic [7:0]  wdata_r;
	logic [7:0]  wdata_nxt;
	logic [15:0] pc_r;
	logic [2:0]  init_cnt_r;
	logic        irq_mask_r;
	logic        fetch_pend_r;
	cbc_mode_t   mode_r;
	logic        cmd_wr_r;
	logic [7:0]  store_r;
	logic [7:0]  y_r;
	logic [7:0]  sp_r;
	logic [7:0]  lo_r;
	logic [7:0]  dir_r;
	logic [7:0]  out_r;
	logic        done_r;
	logic [7:0]  rdata_r;
	logic [15:0] ea_r;
	logic        irq_taken_r;
	logic        stack_adjust_r;
	logic [SYNC_W-1:0] sync_lvl;
	logic        run_lvl;
	logic        irq_lvl;
	logic        aec_lvl;
	logic [7:0]  pins_lvl;
	logic        accept;
	logic        irq_entry;
	logic        int_sel;
	logic        ext_wr;
	logic [7:0]  port_rd;
	logic [7:0]  rd;

	// Eight-bit add with the carry thrown away
	function automatic logic [7:0] add8(input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[7:0];
	endfunction

	function automatic logic [15:0] zp16(input logic [7:0] a);
		return {ZERO_PAGE, a};
	endfunction

	function automatic logic [15:0] stack_at(input logic [7:0] sp, input logic [7:0] dec);
		return {STACK_PAGE, sp - dec};
	endfunction

	function automatic logic int_hit(input logic [15:0] a);
		return (a == PORT_DIR_ADDR) || (a == PORT_OUT_ADDR);
	endfunction

	function automatic logic [15:0] direct_ea(input cbc_mode_t m, input logic [7:0] b2,
	                                          input logic [7:0] b3, input logic [7:0] x,
	                                          input logic [7:0] y);
		logic [15:0] ea;
		ea = {b3, b2};
		unique case (m)
			MODE_ZP:   ea = zp16(b2);
			MODE_ZPX:  ea = zp16(add8(b2, x));
			MODE_ZPY:  ea = zp16(add8(b2, y));
			MODE_ABSX: ea = {b3, b2} + {ZERO_PAGE, x};
			MODE_ABSY: ea = {b3, b2} + {ZERO_PAGE, y};
			default:   ea = {b3, b2};
		endcase
		return ea;
	endfunction

	function automatic logic [15:0] branch_target(input logic [15:0] pc, input logic [7:0] off);
		return pc + {{8{off[7]}}, off};
	endfunction

	function automatic logic [7:0] status_push(input logic [7:0] st, input logic mask);
		logic [7:0] s;
		s = st;
		s[STATUS_MASK_BIT] = mask;
		return s;
	endfunction

	cbc_pin_sync #(
		.W         (SYNC_W),
		.RESET_VAL (SYNC_RESET)
	) u_sync (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.pin_i   ({cpu_reset_n_i, irq_req_n_i, address_drive_enable_i, port_pins_i}),
		.level_o (sync_lvl)
	);

	assign run_lvl  = sync_lvl[10];
	assign irq_lvl  = ~sync_lvl[9];
	assign aec_lvl  = sync_lvl[8];
	assign pins_lvl = sync_lvl[7:0];

	assign accept    = (state_r == ST_IDLE) && cmd_valid_i && run_lvl;
	assign irq_entry = accept && (cmd_mode_i == MODE_FETCH) && irq_lvl && !irq_mask_r;

	// Read data: internal port registers answer their own addresses
	assign int_sel = int_hit(addr_r);
	always_comb begin
		if (addr_r == PORT_DIR_ADDR) begin
			port_rd = dir_r;
		end else begin
			port_rd = (dir_r & out_r) | (~dir_r & pins_lvl);
		end
	end
	assign rd = int_sel ? port_rd : data_lines_i;

	always_comb begin
		state_nxt = state_r;
		addr_nxt  = addr_r;
		wr_nxt    = 1'b0;
		wdata_nxt = wdata_r;
		unique case (state_r)
			ST_HOLD: begin
				if (run_lvl) begin
					state_nxt = ST_INIT;
				end
			end
			ST_INIT: begin
				if (init_cnt_r == INIT_LAST) begin
					addr_nxt  = VEC_RESET_LO;
					state_nxt = ST_VEC_LO;
				end
			end
			ST_IDLE: begin
				if (cmd_valid_i) begin
					unique case (cmd_mode_i)
						MODE_FETCH: begin
							if (irq_lvl && !irq_mask_r) begin
								addr_nxt  = stack_at(stack_ptr_i, ZERO_PAGE);
								wr_nxt    = 1'b1;
								wdata_nxt = pc_r[15:8];
								state_nxt = ST_PUSH_H;
							end else begin
								addr_nxt  = pc_r;
								state_nxt = ST_DATA;
							end
						end
						MODE_IMM, MODE_REL: begin
							state_nxt = ST_IDLE;
						end
						MODE_INDX: begin
							addr_nxt  = zp16(add8(cmd_op1_i, cmd_x_i));
							state_nxt = ST_PTR_LO;
						end
						MODE_INDY: begin
							addr_nxt  = zp16(cmd_op1_i);
							state_nxt = ST_PTR_LO;
						end
						MODE_IND: begin
							addr_nxt  = {cmd_op2_i, cmd_op1_i};
							state_nxt = ST_PTR_LO;
						end
						default: begin
							addr_nxt  = direct_ea(cmd_mode_i, cmd_op1_i, cmd_op2_i, cmd_x_i, cmd_y_i);
							wr_nxt    = cmd_write_i;
							wdata_nxt = cmd_wdata_i;
							state_nxt = ST_DATA;
						end
					endcase
				end
			end
			ST_PTR_LO: begin
				if (mode_r == MODE_IND) begin
					addr_nxt = addr_r + ADDR_STEP;
				end else begin
					addr_nxt = zp16(add8(addr_r[7:0], BYTE_STEP));
				end
				state_nxt = ST_PTR_HI;
			end
			ST_PTR_HI: begin
				if (mode_r == MODE_IND) begin
					state_nxt = ST_IDLE;
				end else begin
					if (mode_r == MODE_INDY) begin
						addr_nxt = {rd, lo_r} + {ZERO_PAGE, y_r};
					end else begin
						addr_nxt = {rd, lo_r};
					end
					wr_nxt    = cmd_wr_r;
					wdata_nxt = store_r;
					state_nxt = ST_DATA;
				end
			end
			ST_DATA: begin
				state_nxt = ST_IDLE;
			end
			ST_PUSH_H: begin
				addr_nxt  = stack_at(sp_r, PUSH_LO_DEC);
				wr_nxt    = 1'b1;
				wdata_nxt = pc_r[7:0];
				state_nxt = ST_PUSH_L;
			end
			ST_PUSH_L: begin
				addr_nxt  = stack_at(sp_r, PUSH_P_DEC);
				wr_nxt    = 1'b1;
				wdata_nxt = status_push(status_i, irq_mask_r);
				state_nxt = ST_PUSH_P;
			end
			ST_PUSH_P: begin
				addr_nxt  = VEC_IRQ_LO;
				state_nxt = ST_VEC_LO;
			end
			ST_VEC_LO: begin
				addr_nxt  = addr_r + ADDR_STEP;
				state_nxt = ST_VEC_HI;
			end
			ST_VEC_HI: begin
				if (fetch_pend_r) begin
					addr_nxt  = {rd, lo_r};
					state_nxt = ST_DATA;
				end else begin
					state_nxt = ST_IDLE;
				end
			end
			default: begin
				state_nxt = ST_HOLD;
			end
		endcase
		// A low reset pin aborts everything and blocks writes
		if (!run_lvl) begin
			state_nxt = ST_HOLD;
			wr_nxt    = 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			state_r <= ST_HOLD;
			addr_r  <= PC_RESET;
			wr_r    <= 1'b0;
			wdata_r <= PORT_RESET;
		end else begin
			state_r <= state_nxt;
			addr_r  <= addr_nxt;
			wr_r    <= wr_nxt;
			wdata_r <= wdata_nxt;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			init_cnt_r <= '0;
		end else if (state_r == ST_INIT) begin
			init_cnt_r <= init_cnt_r + INIT_STEP;
		end else begin
			init_cnt_r <= '0;
		end
	end

	// Command fields kept for the later steps of a multi-cycle access
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			mode_r   <= MODE_FETCH;
			cmd_wr_r <= 1'b0;
			store_r  <= PORT_RESET;
			y_r      <= PORT_RESET;
			sp_r     <= PORT_RESET;
		end else if (accept) begin
			mode_r   <= cmd_mode_i;
			cmd_wr_r <= cmd_write_i;
			store_r  <= cmd_wdata_i;
			y_r      <= cmd_y_i;
			sp_r     <= stack_ptr_i;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			fetch_pend_r <= 1'b0;
		end else if (irq_entry) begin
			fetch_pend_r <= 1'b1;
		end else if (state_r == ST_VEC_HI || state_r == ST_HOLD) begin
			fetch_pend_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			lo_r <= PORT_RESET;
		end else if (state_r == ST_PTR_LO || state_r == ST_VEC_LO) begin
			lo_r <= rd;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			pc_r <= PC_RESET;
		end else if (state_r == ST_VEC_HI) begin
			pc_r <= {rd, lo_r};
		end else if (state_r == ST_PTR_HI && mode_r == MODE_IND) begin
			pc_r <= {rd, lo_r};
		end else if (state_r == ST_DATA && mode_r == MODE_FETCH) begin
			pc_r <= pc_r + ADDR_STEP;
		end else if (accept && cmd_mode_i == MODE_REL && cmd_taken_i) begin
			pc_r <= branch_target(pc_r, cmd_op1_i);
		end
	end

	// Hardware sets of the mask win over a software clear
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_mask_r <= 1'b1;
		end else if (state_r == ST_INIT && init_cnt_r == INIT_LAST) begin
			irq_mask_r <= 1'b1;
		end else if (state_r == ST_PUSH_P) begin
			irq_mask_r <= 1'b1;
		end else if (mask_set_i) begin
			irq_mask_r <= 1'b1;
		end else if (mask_clear_i) begin
			irq_mask_r <= 1'b0;
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			dir_r <= PORT_RESET;
			out_r <= PORT_RESET;
		end else if (wr_r && int_sel && run_lvl) begin
			if (addr_r == PORT_DIR_ADDR) begin
				dir_r <= wdata_r;
			end else begin
				out_r <= wdata_r;
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			done_r  <= 1'b0;
			rdata_r <= PORT_RESET;
			ea_r    <= PC_RESET;
		end else begin
			done_r <= 1'b0;
			if (accept && cmd_mode_i == MODE_IMM) begin
				done_r  <= 1'b1;
				rdata_r <= cmd_op1_i;
			end else if (accept && cmd_mode_i == MODE_REL) begin
				done_r <= 1'b1;
				ea_r   <= branch_target(pc_r, cmd_op1_i);
			end else if (state_r == ST_PTR_HI && mode_r == MODE_IND) begin
				done_r <= 1'b1;
				ea_r   <= {rd, lo_r};
			end else if (state_r == ST_DATA) begin
				done_r <= 1'b1;
				ea_r   <= addr_r;
				if (!wr_r) begin
					rdata_r <= rd;
				end
			end
		end
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			irq_taken_r    <= 1'b0;
			stack_adjust_r <= 1'b0;
		end else begin
			irq_taken_r    <= irq_entry;
			stack_adjust_r <= (state_r == ST_PUSH_P);
		end
	end

	// Internal port accesses never reach the external bus as writes
	assign ext_wr = wr_r && !int_sel && run_lvl;

	assign address_lines_o    = addr_r;
	assign address_lines_oe_o = aec_lvl;
	assign rw_o               = !ext_wr;
	assign data_lines_o       = wdata_r;
	assign data_lines_oe_o    = ext_wr;
	assign port_pins_o        = out_r;
	assign port_pins_oe_o     = dir_r;
	assign cmd_ready_o        = (state_r == ST_IDLE) && run_lvl;
	assign done_o             = done_r;
	assign rdata_o            = rdata_r;
	assign ea_o               = ea_r;
	assign pc_o               = pc_r;
	assign irq_mask_o         = irq_mask_r;
	assign irq_taken_o        = irq_taken_r;
	assign stack_adjust_o     = stack_adjust_r;

endmodule
`default_nettype wire

// *** rtl/cbc_pkg.sv ***
/*
 Shared constants of the bus control and address generation block: bus
 addresses of the on-chip port, start-up and interrupt vectors, reset values,
 counts, addressing modes and sequencer states.
 Assumes it is compiled before the block's modules.
*/
// How it works
// - No bus write while reset pin low
// - Reset pin rising edge starts reset sequence
// - Six cycles, set mask, load FFFC/FFFD
// - Interrupt waits until current instruction finishes
// - Interrupt taken only with mask flag clear
// - Entry pushes program counter and status register
// - Mask flag set after state is saved
// - Vector FFFE/FFFF loaded into program counter
// - Address lines driven only while enable high
// - Port direction at 0000, output at 0001
// - Read/write line low only in writes
// - Data lines driven only during write cycles
// - Immediate operand is byte two, no access
// - Absolute address is byte three, byte two
// - Zero page forces high address byte zero
// - Zero page indexed wraps inside page zero
// - Absolute indexed adds X or Y
// - Branch adds signed offset to next PC
// - Pre-indexed pointer wraps, reads low then high
// - Post-indexed adds Y, carry into high byte
// - Absolute indirect loads full program counter
// - Each port pin direction set individually
`default_nettype none
package cbc_pkg;

	localparam logic [15:0] PORT_DIR_ADDR = 16'h0000;
	localparam logic [15:0] PORT_OUT_ADDR = 16'h0001;
	localparam logic [15:0] VEC_RESET_LO  = 16'hfffc;
	localparam logic [15:0] VEC_IRQ_LO    = 16'hfffe;
	localparam logic [15:0] PC_RESET      = 16'h0000;
	localparam logic [15:0] ADDR_STEP     = 16'h0001;
	localparam logic [7:0]  ZERO_PAGE     = 8'h00;
	localparam logic [7:0]  STACK_PAGE    = 8'h01;
	localparam logic [7:0]  PORT_RESET    = 8'h00;
	localparam logic [7:0]  BYTE_STEP     = 8'h01;
	localparam logic [7:0]  PUSH_LO_DEC   = 8'h01;
	localparam logic [7:0]  PUSH_P_DEC    = 8'h02;
	localparam int          STATUS_MASK_BIT = 2;

	// Start-up delay after the reset pin is released, in clock cycles
	localparam int          INIT_CYCLES   = 6;
	localparam logic [2:0]  INIT_LAST     = 3'(INIT_CYCLES - 1);
	localparam logic [2:0]  INIT_STEP     = 3'h1;

	// Synchroniser lanes: reset pin, interrupt pin, address enable, port pins
	localparam int          SYNC_W        = 11;
	localparam logic [10:0] SYNC_RESET    = 11'h200;

	typedef enum logic [3:0] {
		MODE_FETCH = 4'h0,
		MODE_IMM   = 4'h1,
		MODE_ABS   = 4'h2,
		MODE_ZP    = 4'h3,
		MODE_ZPX   = 4'h4,
		MODE_ZPY   = 4'h5,
		MODE_ABSX  = 4'h6,
		MODE_ABSY  = 4'h7,
		MODE_REL   = 4'h8,
		MODE_INDX  = 4'h9,
		MODE_INDY  = 4'ha,
		MODE_IND   = 4'hb
	} cbc_mode_t;

	typedef enum logic [10:0] {
		ST_HOLD   = 11'h001,
		ST_INIT   = 11'h002,
		ST_VEC_LO = 11'h004,
		ST_VEC_HI = 11'h008,
		ST_IDLE   = 11'h010,
		ST_PTR_LO = 11'h020,
		ST_PTR_HI = 11'h040,
		ST_DATA   = 11'h080,
		ST_PUSH_H = 11'h100,
		ST_PUSH_L = 11'h200,
		ST_PUSH_P = 11'h400
	} cbc_state_t;

endpackage
`default_nettype wire

// *** rtl/cbc_pin_sync.sv ***
/*
 Three-stage synchroniser with an agreement filter for asynchronous pins.
 Assumes every lane is a slow level; a lane changes once stages two and
 three agree.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_pin_sync #(
	parameter int             W         = 1,
	parameter logic [W-1:0]   RESET_VAL = '0
) (
	input  wire logic         clk_i,
	input  wire logic         reset_i,
	input  wire logic [W-1:0] pin_i,
	output logic      [W-1:0] level_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] level_r;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			s1_r <= RESET_VAL;
			s2_r <= RESET_VAL;
			s3_r <= RESET_VAL;
		end else begin
			s1_r <= pin_i;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// Lanes whose last two stages disagree keep their old level
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			level_r <= RESET_VAL;
		end else begin
			level_r <= (~(s2_r ^ s3_r) & s3_r) | ((s2_r ^ s3_r) & level_r);
		end
	end

	assign level_o = level_r;

endmodule
`default_nettype wire

// *** testbench/cbc_bus_ctl_checker.sv ***
/*
 Port assertions for the bus control and address generation block.
 Assumes it is bound to cbc_bus_ctl and that the pins lag about four clocks.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl_checker
	import cbc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        reset_i,
	input wire logic        cpu_reset_n_i,
	input wire logic        address_drive_enable_i,
	input wire logic [15:0] address_lines_o,
	input wire logic        address_lines_oe_o,
	input wire logic [7:0]  data_lines_o,
	input wire logic        data_lines_oe_o,
	input wire logic        rw_o,
	input wire logic        cmd_valid_i,
	input wire logic        cmd_ready_o,
	input wire cbc_mode_t   cmd_mode_i,
	input wire logic [7:0]  cmd_op1_i,
	input wire logic [7:0]  cmd_op2_i,
	input wire logic [7:0]  cmd_x_i,
	input wire logic [7:0]  cmd_y_i,
	input wire logic        done_o,
	input wire logic [7:0]  rdata_o,
	input wire logic        irq_mask_o,
	input wire logic        irq_taken_o,
	input wire logic        stack_adjust_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	wire logic take = cmd_valid_i && cmd_ready_o;

	sequence push_s;
		(address_lines_o[15:8] == 8'h01 && !rw_o)[*3];
	endsequence
	sequence irq_vec_s;
		address_lines_o == 16'hfffe && irq_mask_o && rw_o ##1 address_lines_o == 16'hffff && rw_o;
	endsequence
	sequence rst_vec_s;
		address_lines_o == 16'hfffc && irq_mask_o && rw_o ##1 address_lines_o == 16'hfffd && rw_o;
	endsequence

	a_no_write_reset: assert property ((!cpu_reset_n_i)[*6] |-> rw_o && !data_lines_oe_o)
		else $error("write while reset pin low");
	a_rw_data_drive: assert property (data_lines_oe_o == !rw_o)
		else $error("data drive and direction disagree");
	a_addr_drive_on: assert property (address_drive_enable_i[*6] |-> address_lines_oe_o)
		else $error("address not driven while enabled");
	a_addr_drive_off: assert property ((!address_drive_enable_i)[*6] |-> !address_lines_oe_o)
		else $error("address driven while disabled");
	a_reset_vector_fetch: assert property ($rose(cpu_reset_n_i) |-> ##[9:13] rst_vec_s)
		else $error("start-up vector not fetched in time");
	a_irq_entry_order: assert property (irq_taken_o |-> push_s ##1 irq_vec_s)
		else $error("interrupt entry out of order");
	a_status_mask_clear: assert property (irq_taken_o |-> ##2 !data_lines_o[2])
		else $error("pushed status has mask set");
	a_irq_when_unmasked: assert property (irq_taken_o |-> !$past(irq_mask_o))
		else $error("interrupt taken while masked");
	a_irq_at_boundary: assert property (irq_taken_o |-> $past(take) && $past(cmd_mode_i) == MODE_FETCH)
		else $error("interrupt taken off a boundary");
	a_zp_index_wrap: assert property (take && cmd_mode_i == MODE_ZPX
		|=> address_lines_o == {8'h00, 8'($past(cmd_op1_i) + $past(cmd_x_i))})
		else $error("zero page index left page zero");
	a_abs_index_add: assert property (take && cmd_mode_i == MODE_ABSY
		|=> address_lines_o == {$past(cmd_op2_i), $past(cmd_op1_i)} + {8'h00, $past(cmd_y_i)})
		else $error("absolute indexed address wrong");
	a_imm_operand: assert property (take && cmd_mode_i == MODE_IMM |=> done_o && rdata_o == $past(cmd_op1_i))
		else $error("immediate operand wrong");
	a_stack_adjust_pulse: assert property (irq_taken_o |-> ##3 stack_adjust_o)
		else $error("stack adjust not flagged after pushes");
endmodule
bind cbc_bus_ctl cbc_bus_ctl_checker chk_u (.clk_i, .reset_i, .cpu_reset_n_i, .address_drive_enable_i,
	.address_lines_o, .address_lines_oe_o, .data_lines_o, .data_lines_oe_o, .rw_o, .cmd_valid_i, .cmd_ready_o,
	.cmd_mode_i, .cmd_op1_i, .cmd_op2_i, .cmd_x_i, .cmd_y_i, .done_o, .rdata_o, .irq_mask_o, .irq_taken_o,
	.stack_adjust_o);
`default_nettype wire

// *** testbench/cbc_mem_model.sv ***
/*
 Memory on the far side of the bus, filled with an address-derived pattern.
 Assumes reads are answered within the same clock cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_mem_model (
	input wire logic        clk_i,
	input wire logic [15:0] addr_i,
	input wire logic        rw_i,
	input wire logic        oe_i,
	input wire logic [7:0]  wdata_i,
	output logic     [7:0]  rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] last_r;

	initial begin
		last_r = 8'h00;
		for (int a = 0; a < 65536; a++) begin
			mem[a] = 8'(a) ^ 8'(a >> 8) ^ 8'h5a;
		end
	end
	// Plain always: the array is also filled by the initial block
	always @(posedge clk_i) begin
		if (!rw_i && oe_i) begin
			mem[addr_i] <= wdata_i;
		end else if (rw_i) begin
			last_r <= mem[addr_i];
		end
	end
	// Released bus shows the inverse so a stale value never matches
	assign rdata_o = rw_i ? mem[addr_i] : ~last_r;
endmodule
`default_nettype wire

// *** testbench/cbc_bus_ctl_bench.sv ***
/*
 Self-checking bench for the bus control block with a memory partner.
 Assumes the package and design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module cbc_bus_ctl_bench;
	import cbc_pkg::*;
	logic        clk_i = 0, reset_i = 1, rst_n = 0, irq_n = 1, aec = 0, valid = 0, wr = 0, taken = 0, mclr = 0;
	logic [7:0]  pins = 8'h00, wd = 8'h00, op1 = 8'h00, op2 = 8'h00, xr = 8'h00, yr = 8'h00, dq, dout, pin_o, pin_oe;
	cbc_mode_t   mode = MODE_FETCH;
	logic [15:0] addr, ea, pc;
	logic        aoe, doe, rw, ready, done, msk, itk, sadj, tk;
	logic [7:0]  rdata;
	int          err_total = 0, n_tests = 0;

	always #5 clk_i = ~clk_i;

	cbc_bus_ctl uut (.clk_i(clk_i), .reset_i(reset_i), .cpu_reset_n_i(rst_n), .irq_req_n_i(irq_n),
		.address_drive_enable_i(aec), .address_lines_o(addr), .address_lines_oe_o(aoe), .data_lines_i(dq),
		.data_lines_o(dout), .data_lines_oe_o(doe), .rw_o(rw), .port_pins_i(pins), .port_pins_o(pin_o),
		.port_pins_oe_o(pin_oe), .cmd_valid_i(valid), .cmd_ready_o(ready), .cmd_mode_i(mode), .cmd_write_i(wr),
		.cmd_wdata_i(wd), .cmd_op1_i(op1), .cmd_op2_i(op2), .cmd_x_i(xr), .cmd_y_i(yr), .cmd_taken_i(taken),
		.status_i(8'hff), .stack_ptr_i(8'hff), .mask_set_i(1'b0), .mask_clear_i(mclr), .done_o(done),
		.rdata_o(rdata), .ea_o(ea), .pc_o(pc), .irq_mask_o(msk), .irq_taken_o(itk), .stack_adjust_o(sadj));
	cbc_mem_model mem_u (.clk_i(clk_i), .addr_i(addr), .rw_i(rw), .oe_i(doe), .wdata_i(dout), .rdata_o(dq));

	function automatic logic [7:0] mv(logic [15:0] a);
		return mem_u.mem[a];
	endfunction
	task automatic chk(logic ok, string s);
		n_tests++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("ERROR %0t %s", $time, s);
		end
	endtask
	task automatic op(cbc_mode_t m, logic w, logic [7:0] d, a, b, x, y, logic t);
		int k;
		@(negedge clk_i);
		mode = m; wr = w; wd = d; op1 = a; op2 = b; xr = x; yr = y; taken = t; valid = 1;
		while (ready !== 1'b1) @(negedge clk_i);
		@(negedge clk_i);
		valid = 0;
		tk = itk;
		k = 0;
		while (done !== 1'b1 && k < 20) begin
			@(negedge clk_i);
			k++;
		end
		chk(done === 1'b1, "no completion");
	endtask
	task automatic rd(cbc_mode_t m, logic [7:0] a, b, x, y, logic [15:0] e);
		op(m, 0, 8'h00, a, b, x, y, 0);
		chk(ea_o_ok(e), "effective address");
		chk(rdata === mv(e), "read data");
	endtask
	function automatic logic ea_o_ok(logic [15:0] e);
		return ea === e;
	endfunction
	task automatic t_reset;
		int k;
		repeat (6) @(negedge clk_i);
		chk(rw === 1'b1 && ready === 1'b0 && aoe === 1'b0, "bus active in reset");
		aec = 1; rst_n = 1; k = 0;
		while (ready !== 1'b1 && k < 40) begin
			@(negedge clk_i);
			k++;
		end
		chk(k == 13, "start-up length");
		chk(pc === {mv(16'hfffd), mv(16'hfffc)} && msk === 1'b1, "start-up vector");
		chk(aoe === 1'b1, "address not driven");
	endtask
	task automatic t_port;
		pins = 8'h3c;
		op(MODE_ZP, 1, 8'h0f, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		op(MODE_ZP, 1, 8'ha5, 8'h01, 8'h00, 8'h00, 8'h00, 0);
		chk(pin_oe === 8'h0f && pin_o === 8'ha5 && mv(16'h0000) === 8'h5a, "port write");
		op(MODE_ZP, 0, 8'h00, 8'h01, 8'h00, 8'h00, 8'h00, 0);
		chk(rdata === 8'h35, "port read mixes pins");
		op(MODE_ZP, 0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		chk(rdata === 8'h0f, "direction read");
	endtask
	task automatic t_modes;
		op(MODE_IMM, 0, 8'h00, 8'h99, 8'h00, 8'h00, 8'h00, 0);
		chk(rdata === 8'h99, "immediate");
		op(MODE_ABSX, 1, 8'hc3, 8'hf0, 8'h12, 8'h20, 8'h00, 0);
		chk(mv(16'h1310) === 8'hc3 && ea === 16'h1310, "indexed store");
		rd(MODE_ABS, 8'h34, 8'h12, 8'h00, 8'h00, 16'h1234);
		rd(MODE_ZP, 8'h77, 8'h12, 8'h00, 8'h00, 16'h0077);
		rd(MODE_ZPX, 8'hf0, 8'h12, 8'h20, 8'h00, 16'h0010);
		rd(MODE_ZPY, 8'h80, 8'h12, 8'h00, 8'h85, 16'h0005);
		rd(MODE_ABSY, 8'hf0, 8'h12, 8'h00, 8'h20, 16'h1310);
		rd(MODE_INDX, 8'hfe, 8'h00, 8'h01, 8'h00, {8'h0f, mv(16'h00ff)});
		rd(MODE_INDY, 8'h20, 8'h00, 8'h00, 8'h90, {mv(16'h0021), mv(16'h0020)} + 16'h0090);
		op(MODE_IND, 0, 8'h00, 8'h00, 8'h20, 8'h00, 8'h00, 0);
		chk(pc === {mv(16'h2001), mv(16'h2000)}, "indirect jump");
		op(MODE_REL, 0, 8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 1);
		chk(pc === 16'h7afa && ea === 16'h7afa, "branch back");
		op(MODE_REL, 0, 8'h00, 8'h7f, 8'h00, 8'h00, 8'h00, 0);
		chk(pc === 16'h7afa && ea === 16'h7b79, "branch not taken");
	endtask
	task automatic t_irq;
		@(negedge clk_i);
		mclr = 1; irq_n = 0;
		@(negedge clk_i);
		mclr = 0;
		repeat (6) @(negedge clk_i);
		rd(MODE_ZP, 8'h77, 8'h00, 8'h00, 8'h00, 16'h0077);
		chk(tk === 1'b0, "interrupt inside instruction");
		op(MODE_FETCH, 0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		chk(tk === 1'b1 && msk === 1'b1, "interrupt entry");
		chk(mv(16'h01ff) === 8'h7a && mv(16'h01fe) === 8'hfa && mv(16'h01fd) === 8'hfb, "stacked state");
		chk(pc === {mv(16'hffff), mv(16'hfffe)} + 16'h0001, "interrupt vector");
		op(MODE_FETCH, 0, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 0);
		chk(tk === 1'b0, "masked request taken");
		irq_n = 1;
	endtask
	task automatic t_pin_reset;
		int k;
		@(negedge clk_i);
		rst_n = 0;
		repeat (6) @(negedge clk_i);
		chk(rw === 1'b1 && doe === 1'b0 && ready === 1'b0, "bus active in pin reset");
		rst_n = 1; k = 0;
		while (ready !== 1'b1 && k < 40) begin
			@(negedge clk_i);
			k++;
		end
		chk(k == 13, "restart length");
		chk(pc === {mv(16'hfffd), mv(16'hfffc)} && msk === 1'b1, "restart vector");
		chk(pin_oe === 8'h0f && pin_o === 8'ha5, "port kept over pin reset");
	endtask
	task automatic wrap_up;
		$display("comparisons %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		repeat (5) @(negedge clk_i);
		reset_i = 0;
		t_reset();
		t_port();
		t_modes();
		t_irq();
		t_pin_reset();
		wrap_up();
	end
	initial begin
		#20000;
		err_total++;
		wrap_up();
	end
endmodule
`default_nettype wire
